/* File: shared/gauge_cfg_pkg.sv */
// ==========================================================
// constants and carriers for the configuration word decoder
package gauge_cfg_pkg;
    localparam int CFG_W = 16;                 // configuration word width
    localparam int BYTE_W = 8;                 // bits per link byte
    localparam logic [6:0] SLAVE_ADDR = 7'h47; // fixed 7-bit slave address
    localparam logic [3:0] ACK_SLOT = 4'h8;    // bit count of the ack clock
    // bit positions inside the configuration word
    localparam int B_DIR_EN = 10;
    localparam int B_SLEEP = 9;
    localparam int B_ZERO = 8;
    localparam int B_CLEAR = 7;
    localparam int B_SELECT = 6;
    localparam int B_CAL = 5;
    localparam int B_CMP_EN = 4;
    localparam int B_DIS_HI = 3;
    localparam int B_DIS_LO = 2;
    localparam int B_CHG_HI = 1;
    localparam int B_CHG_LO = 0;

    // byte position inside a write-word frame
    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_CMD = 2'b01,
        PH_LO = 2'b10,
        PH_HI = 2'b11
    } link_phase_t;

    // persistent configuration fields
    typedef struct packed {
        logic dir_change_irq_en;
        logic soft_sleep_en;
        logic tally_select;
        logic offset_cal_en;
        logic compare_irq_en;
        logic [1:0] dis_gate_ctl;  // {hi, lo}
        logic [1:0] chg_gate_ctl;  // {hi, lo}
    } cfg_t;

    // sticky interrupt status flags
    typedef struct packed {
        logic dis_overcurrent_flag;
        logic chg_overcurrent_flag;
        logic compare_hit_flag;
        logic flow_reversal_flag;
    } flags_t;

    // link-side state, clocked by the bus clock
    typedef struct packed {
        link_phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic addr_hit;
        logic cmd_ok;
        logic [7:0] lo_byte;
        logic [CFG_W-1:0] word;
        logic word_tgl;
        logic stop_wait;  // next rise is the stop clock, carries no data
    } link_st_t;

    // core-side state, clocked by the reference clock
    typedef struct packed {
        logic [2:0] tgl_sync;
        cfg_t cfg;
        flags_t flags;
        logic zero_tallies_cmd;
        logic alert_oe;
    } core_st_t;
endpackage

/* File: hdl/gauge_config_word_decoder.sv */
// What this block does
// [RULE1] bit 10 enables direction-change interrupt
// [RULE2] bit 9 holds soft shutdown while set
// [RULE3] bit 8 write clears both coulomb totals
// [RULE4] bit 7 write clears all four flags
// [RULE5] bit 6 selects charge or discharge total
// [RULE6] bit 5 grounds sense input for offset
// [RULE7] bit 4 enables digital compare interrupt
// [RULE8] bits 3:2 set discharge fet drive
// [RULE9] bits 1:0 set charge fet drive
// [RULE10] host keeps bit 2 cleared
// [RULE11] host keeps bit 0 cleared
// [RULE12] answer only fixed address, write-word frames
// [RULE13] select echo flag mirrors bit 6
// [RULE14] clear flow flag on clear or sleep
// [RULE15] alert line signals enabled interrupt
// [RULE16] clear bits act as one pulse
// [RULE17] bits 15 to 11 ignored
`timescale 1ns/1ns
`default_nettype none
module gauge_config_word_decoder
    import gauge_cfg_pkg::*;
#(
    parameter logic [7:0] CFG_CMD_CODE = 8'h00 // command code of the config write
) (
    input wire logic ref_clk_in,              // 10 MHz core clock
    input wire logic rst_n_in,                // async active-low reset
    input wire logic scl_in,                  // bus clock from the host
    input wire logic sda_in,                  // bus data level
    output logic sda_out,                     // bus data drive level
    output logic sda_oe_out,                  // bus data drive enable
    output logic alert_out,                   // alert drive level
    output logic alert_oe_out,                // alert drive enable
    input wire logic dis_oc_evt_in,           // discharge overcurrent event
    input wire logic chg_oc_evt_in,           // charge overcurrent event
    input wire logic compare_evt_in,          // counter compare event
    input wire logic flow_rev_evt_in,         // current direction change event
    output cfg_t cfg_out,                     // decoded configuration
    output flags_t flags_out,                 // sticky status flags
    output logic select_echo_flag_out,        // echo of counter select
    output logic zero_tallies_out,            // one-cycle counter clear
    output logic [1:0] discharge_fet_drive_out, // discharge driver control
    output logic [1:0] charge_fet_drive_out   // charge driver control
);
    // ==========================================================
    // reset release into the core domain
    logic [1:0] rst_sync_q; // two-stage release
    logic rst_core_n;       // synchronised reset

    // release the reset through two flip-flops
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_q[1];

    // ==========================================================
    // link side: bit engine on the bus clock
    link_st_t lq, ld;   // link state and next value
    logic ack_want;     // ack due in the coming slot
    logic ack_q;        // ack driven from the falling edge

    // ack only a matching write address, then the rest of that frame
    always_comb begin
        ack_want = 1'b0;
        if (lq.bit_cnt == ACK_SLOT) begin
            if (lq.phase == PH_ADDR) begin
                ack_want = (lq.shift == {SLAVE_ADDR, 1'b0}); // [RULE12]
            end else begin
                ack_want = lq.addr_hit;
            end
        end
    end

    // shift bits, close bytes, hand the word over at frame end
    always_comb begin
        ld = lq;
        if (lq.stop_wait) begin
            // stop clock after the last ack: skip it so frames stay aligned
            ld.stop_wait = 1'b0; // [RULE12]
        end else if (lq.bit_cnt == ACK_SLOT) begin
            // ack clock: byte complete
            ld.bit_cnt = 4'h0;
            ld.phase = link_phase_t'(2'(lq.phase + 2'h1));
            case (lq.phase)
                PH_ADDR: begin
                    ld.addr_hit = (lq.shift == {SLAVE_ADDR, 1'b0}); // [RULE12]
                end
                PH_CMD: begin
                    ld.cmd_ok = (lq.shift == CFG_CMD_CODE); // [RULE12]
                end
                PH_LO: begin
                    ld.lo_byte = lq.shift; // low byte comes first
                end
                PH_HI: begin
                    // a write-word frame always ends with a stop clock
                    ld.stop_wait = 1'b1; // [RULE12]
                    // whole word accepted: publish and toggle
                    if (lq.addr_hit && lq.cmd_ok) begin
                        ld.word = {lq.shift, lq.lo_byte};
                        ld.word_tgl = ~lq.word_tgl;
                    end
                end
                default: begin
                    ld.phase = PH_ADDR;
                end
            endcase
        end else begin
            // data clock: sample msb first
            ld.shift = {lq.shift[BYTE_W-2:0], sda_in};
            ld.bit_cnt = 4'(lq.bit_cnt + 4'h1);
        end
    end

    // link state register
    always_ff @(posedge scl_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    // ack changes only while the bus clock is low
    always_ff @(negedge scl_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_want;
        end
    end
    assign sda_out = 1'b0;  // open drain pulls low only
    assign sda_oe_out = ack_q;

    // ==========================================================
    // core side: word decode and status flags
    core_st_t cq, cd;  // core state and next value
    logic word_evt;    // new configuration word arrived
    logic [CFG_W-1:0] w; // word held stable by the link side
    logic flag_clr;    // flags clear strobe
    logic alert_req;   // enabled interrupt pending

    // decode the word and update flags
    always_comb begin
        cd = cq;
        w = lq.word; // stable for many core cycles after the toggle
        cd.tgl_sync = {cq.tgl_sync[1:0], lq.word_tgl};
        word_evt = cq.tgl_sync[2] ^ cq.tgl_sync[1];
        cd.zero_tallies_cmd = 1'b0;
        flag_clr = 1'b0;
        if (word_evt) begin
            // bits 15 to 11 are simply never looked at [RULE17]
            cd.cfg.dir_change_irq_en = w[B_DIR_EN]; // [RULE1]
            cd.cfg.soft_sleep_en = w[B_SLEEP];      // [RULE2]
            cd.cfg.tally_select = w[B_SELECT];      // [RULE5]
            cd.cfg.offset_cal_en = w[B_CAL];        // [RULE6]
            cd.cfg.compare_irq_en = w[B_CMP_EN];    // [RULE7]
            cd.cfg.dis_gate_ctl = {w[B_DIS_HI], w[B_DIS_LO]}; // [RULE8]
            cd.cfg.chg_gate_ctl = {w[B_CHG_HI], w[B_CHG_LO]}; // [RULE9]
            cd.zero_tallies_cmd = w[B_ZERO];        // [RULE3] [RULE16]
            flag_clr = w[B_CLEAR] | w[B_SLEEP];     // [RULE4] [RULE14] [RULE16]
        end
        // clear first, so a same-cycle event still sets
        if (flag_clr) begin
            cd.flags = '0; // [RULE4] [RULE14]
        end
        if (dis_oc_evt_in) begin
            cd.flags.dis_overcurrent_flag = 1'b1;
        end
        if (chg_oc_evt_in) begin
            cd.flags.chg_overcurrent_flag = 1'b1;
        end
        if (compare_evt_in && cq.cfg.compare_irq_en) begin
            cd.flags.compare_hit_flag = 1'b1; // [RULE7]
        end
        if (flow_rev_evt_in) begin
            cd.flags.flow_reversal_flag = 1'b1;
        end
        // alert for either overcurrent flag, the compare flag, or the flow flag when enabled
        alert_req = cq.flags.dis_overcurrent_flag | cq.flags.chg_overcurrent_flag
            | cq.flags.compare_hit_flag
            | (cq.flags.flow_reversal_flag & cq.cfg.dir_change_irq_en); // [RULE15] [RULE1]
        cd.alert_oe = alert_req; // [RULE15]
    end

    // core state register
    always_ff @(posedge ref_clk_in or negedge rst_core_n) begin
        if (!rst_core_n) begin
            cq <= '0;
        end else begin
            cq <= cd;
        end
    end

    // registered outputs
    assign cfg_out = cq.cfg;
    assign flags_out = cq.flags;
    assign select_echo_flag_out = cq.cfg.tally_select; // [RULE13]
    assign zero_tallies_out = cq.zero_tallies_cmd;     // [RULE3]
    assign discharge_fet_drive_out = cq.cfg.dis_gate_ctl; // [RULE8]
    assign charge_fet_drive_out = cq.cfg.chg_gate_ctl;    // [RULE9]
    assign alert_out = 1'b0;  // open drain pulls low only
    assign alert_oe_out = cq.alert_oe;

    // ==========================================================
    // checks
    a_dir_en_load: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        word_evt |=> cfg_out.dir_change_irq_en == $past(w[B_DIR_EN])) // [RULE1]
        else $error("direction interrupt enable not loaded");
    a_sleep_load: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        !word_evt |=> $stable(cfg_out.soft_sleep_en)) // [RULE2]
        else $error("soft sleep changed without a write");
    a_zero_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        word_evt && w[B_ZERO] |=> zero_tallies_out ##1 !zero_tallies_out) // [RULE3]
        else $error("counter clear not a single pulse");
    a_flags_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        word_evt && w[B_CLEAR] && !dis_oc_evt_in |=> !flags_out.dis_overcurrent_flag) // [RULE4]
        else $error("flag clear ignored");
    a_select_load: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        word_evt |=> cfg_out.tally_select == $past(w[B_SELECT])) // [RULE5]
        else $error("counter select not loaded");
    a_cal_load: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        word_evt |=> cfg_out.offset_cal_en == $past(w[B_CAL])) // [RULE6]
        else $error("offset mode not loaded");
    a_compare_gate: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        $rose(flags_out.compare_hit_flag) |-> $past(cfg_out.compare_irq_en)) // [RULE7]
        else $error("compare flag set while disabled");
    a_gate_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        word_evt |=> discharge_fet_drive_out == $past(w[B_DIS_HI:B_DIS_LO])
            && charge_fet_drive_out == $past(w[B_CHG_HI:B_CHG_LO])) // [RULE8]
        else $error("fet drive controls not loaded");
    a_echo_match: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        word_evt |=> select_echo_flag_out == $past(w[B_SELECT])) // [RULE13]
        else $error("select echo differs");
    a_flow_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        word_evt && w[B_SLEEP] && !flow_rev_evt_in |=> !flags_out.flow_reversal_flag) // [RULE14]
        else $error("sleep write left flow flag set");
    a_alert_follow: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        flags_out.dis_overcurrent_flag |=> alert_oe_out) // [RULE15]
        else $error("alert not raised");
    a_event_wins: assert property (@(posedge ref_clk_in) disable iff (!rst_core_n)
        chg_oc_evt_in |=> flags_out.chg_overcurrent_flag) // [RULE16]
        else $error("event lost against a clear");
    c_word_in: cover property (@(posedge ref_clk_in) disable iff (!rst_core_n) word_evt);
    c_zero: cover property (@(posedge ref_clk_in) disable iff (!rst_core_n) zero_tallies_out);
    c_alert: cover property (@(posedge ref_clk_in) disable iff (!rst_core_n) $rose(alert_oe_out));
endmodule
`default_nettype wire

/* File: sim/smbus_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// host model: write-word master, bus clock parked high between frames
module smbus_host_model (
    input wire logic sda_oe_in, // device pulls data low
    output logic scl_out,       // bus clock, 48 ns period inside frames
    output logic sda_out        // resolved data wire
);
    logic host_low; // host pulls data low
    // open-drain wire with pull-up: released means high
    assign sda_out = ~(host_low | sda_oe_in);
    initial begin
        scl_out = 1'b1;
        host_low = 1'b0;
    end
    // one byte msb first, data moves only while the clock is low
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #12 host_low = ~b[i];
            #12 scl_out = 1'b1;
            #24 scl_out = 1'b0;
        end
        #12 host_low = 1'b0;
        #12 scl_out = 1'b1;
        ack = ~sda_out;
        #24 scl_out = 1'b0;
    endtask
    // start, address, command, low then high data byte, stop
    task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd,
            input logic [15:0] w, output logic [3:0] acks);
        #7 host_low = 1'b1;
        #12 scl_out = 1'b0;
        send_byte({addr, 1'b0}, acks[3]);
        send_byte(cmd, acks[2]);
        send_byte(w[7:0], acks[1]);
        send_byte(w[15:8], acks[0]);
        #12 host_low = 1'b1;
        #12 scl_out = 1'b1;
        #12 host_low = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: sim/gauge_config_word_decoder_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// self-checking bench for the configuration word decoder
module gauge_config_word_decoder_tb;
    import gauge_cfg_pkg::*;
    logic ref_clk_in, rst_n_in, scl, sda, sda_drv, sda_oe, alert_drv, alert_oe;
    logic [3:0] evt;           // {dis_oc, chg_oc, compare, flow_rev}
    cfg_t cfg, exp_cfg;
    flags_t flags, exp_flags;
    logic echo, zero_pulse;
    logic [1:0] dis_drive, chg_drive;
    logic [3:0] acks;
    logic [15:0] rng, w;
    int bad_count, tests_run, zero_seen, exp_zero;
    gauge_config_word_decoder u_gauge_config_word_decoder (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
        .sda_oe_out(sda_oe), .alert_out(alert_drv), .alert_oe_out(alert_oe),
        .dis_oc_evt_in(evt[3]), .chg_oc_evt_in(evt[2]), .compare_evt_in(evt[1]),
        .flow_rev_evt_in(evt[0]), .cfg_out(cfg), .flags_out(flags),
        .select_echo_flag_out(echo), .zero_tallies_out(zero_pulse),
        .discharge_fet_drive_out(dis_drive), .charge_fet_drive_out(chg_drive));
    smbus_host_model u_smbus_host_model (.sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
    // ==========================================================
    // clock, pulse counter, helpers
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    // count one-cycle counter-clear pulses, sampled away from the launching edge
    always @(negedge ref_clk_in) begin
        if (zero_pulse === 1'b1) zero_seen++;
    end
    function automatic logic [15:0] xs(input logic [15:0] x);
        x ^= x << 7;
        x ^= x >> 9;
        x ^= x << 8;
        return x;
    endfunction
    // alert expected from the modelled flags and enables
    function automatic logic exp_alert(input flags_t f, input cfg_t c);
        return f.dis_overcurrent_flag | f.chg_overcurrent_flag | f.compare_hit_flag
            | (f.flow_reversal_flag & c.dir_change_irq_en);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic check_all();
        check(16'(cfg), 16'(exp_cfg));
        check(16'(echo), 16'(exp_cfg.tally_select));
        check({dis_drive, chg_drive}, {exp_cfg.dis_gate_ctl, exp_cfg.chg_gate_ctl});
        check(16'(flags), 16'(exp_flags));
        check(16'(alert_oe), 16'(exp_alert(exp_flags, exp_cfg)));
        check(16'({sda_drv, alert_drv}), 16'h0000);
        check(16'(zero_seen), 16'(exp_zero));
    endtask
    // frame, then expected update of fields, flags and clears
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] v);
        u_smbus_host_model.write_word(a, c, v, acks);
        repeat (8) @(negedge ref_clk_in);
        check(16'(acks), (a == SLAVE_ADDR) ? 16'h000F : 16'h0000);
        if (a == SLAVE_ADDR && c == 8'h00) begin
            exp_cfg = cfg_t'({v[10:9], v[6:0]});
            if (v[B_CLEAR] | v[B_SLEEP]) exp_flags = '0;
            if (v[B_ZERO]) exp_zero++;
        end
        check_all();
    endtask
    // one-cycle event pulse; compare hit only counts when enabled
    task automatic pulse(input logic [3:0] e);
        evt = e;
        @(negedge ref_clk_in);
        evt = 4'h0;
        exp_flags = exp_flags | (e & {2'b11, exp_cfg.compare_irq_en, 1'b1});
        repeat (3) @(negedge ref_clk_in);
        check_all();
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // watchdog and main sequence
    initial begin
        #400000;
        bad_count++;
        summarize();
    end
    initial begin
        rst_n_in = 1'b0;
        evt = 4'h0;
        rng = 16'hA320;
        {bad_count, tests_run, zero_seen, exp_zero} = '0;
        exp_cfg = '0;
        exp_flags = '0;
        repeat (4) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        check_all();
        $display("test reset done");
        wr(SLAVE_ADDR, 8'h00, 16'hF80A); // high gate bits set, low kept clear
        wr(SLAVE_ADDR ^ 7'h01, 8'h00, 16'h0000);
        wr(SLAVE_ADDR, 8'h5A, 16'h0000);
        $display("test address and command done");
        wr(SLAVE_ADDR, 8'h00, 16'h0010);
        pulse(4'hF);
        wr(SLAVE_ADDR, 8'h00, 16'h0400);
        wr(SLAVE_ADDR, 8'h00, 16'h0080);
        pulse(4'h1);
        wr(SLAVE_ADDR, 8'h00, 16'h0200);
        pulse(4'h2);
        $display("test flags done");
        for (int i = 0; i < 24; i++) begin
            rng = xs(rng);
            w = rng & 16'hFFFA; // host keeps both low gate bits clear
            wr(SLAVE_ADDR, 8'h00, w);
            rng = xs(rng);
            pulse(rng[3:0]);
        end
        $display("test random done");
        summarize();
    end
endmodule
`default_nettype wire
